// ===== hdl/qci_decoder.sv
/*
  quadrature decoder: count pulse with direction from the phase inputs, index rising edge.
  assumes: inputs already synchronous to the clock; both phases never change together.
*/
`default_nettype none

module qci_decoder (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // encoder pins
  input  wire logic phase_a_in,
  input  wire logic phase_b_in,
  input  wire logic index_input_in,
  // decoded events
  output logic      count_out,
  output logic      dir_up_out,
  output logic      index_out
);

  qci_pkg::qci_dec_type s;
  qci_pkg::qci_dec_type next_s;

  always_comb
  begin
    next_s = s;
    next_s.prev_a = phase_a_in;
    next_s.prev_b = phase_b_in;
    next_s.prev_idx = index_input_in;
    // one phase changed: a quadrature edge
    next_s.cnt = (phase_a_in ^ s.prev_a) ^ (phase_b_in ^ s.prev_b);
    if (next_s.cnt)
    begin
      next_s.dir = phase_a_in ^ s.prev_b;
    end
    next_s.idx = index_input_in & ~s.prev_idx;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign count_out = s.cnt;
  assign dir_up_out = s.dir;
  assign index_out = s.idx;

endmodule

`default_nettype wire

// ===== hdl/qci_map.svh
/*
  register offsets, field positions, codes and reset values of the quadrature capture block.
  assumes: included by the package and the top module; definitions only.
*/
`ifndef QCI_MAP_SVH
`define QCI_MAP_SVH

// register offsets (byte addresses)
`define QCI_CTRL_OFF       8'h00
`define QCI_POS_OFF        8'h04
`define QCI_INIT_OFF       8'h08
`define QCI_MAX_OFF        8'h0C
`define QCI_CMP_OFF        8'h10
`define QCI_UPRD_OFF       8'h14
`define QCI_POSLAT_OFF     8'h18
`define QCI_CAPPRD_OFF     8'h1C
`define QCI_THR_OFF        8'h20
`define QCI_STATUS_OFF     8'h24
`define QCI_IRQEN_OFF      8'h28
`define QCI_IRQST_OFF      8'h2C
`define QCI_IRQCLR_OFF     8'h30
`define QCI_CMPACT_OFF     8'h34

// control register fields
`define QCI_CTRL_EN        0
`define QCI_CTRL_MODE      1
`define QCI_CTRL_UTE       3
`define QCI_CTRL_CAPEN     4
`define QCI_CTRL_CAPPS     5
`define QCI_CTRL_UPPS      8
`define QCI_CTRL_W         11

// position counter reset modes
`define QCI_MODE_EVERY_IDX 2'h0
`define QCI_MODE_MAX_POS   2'h1
`define QCI_MODE_FIRST_IDX 2'h2

// event bits shared by flags, sticky status, enable and clear
`define QCI_EV_DIRCHG      0
`define QCI_EV_UNDER       1
`define QCI_EV_OVER        2
`define QCI_EV_CMP         3
`define QCI_EV_UTO         4
`define QCI_EV_CAPNEW      5
`define QCI_EV_DIRECTION_CHANGE_ERROR_FLAG        6
`define QCI_EV_CAPTURE_OVERFLOW_ERROR_FLAG        7
`define QCI_EV_W           8

// status register fields
`define QCI_ST_DIR         0
`define QCI_ST_FIRST       1
`define QCI_ST_LOWSPD      2

// reset values and the capture timer full count
`define QCI_CTRL_RST       11'h000
`define QCI_MAX_RST        32'hFFFFFFFF
`define QCI_UPRD_RST       32'h0000FFFF
`define QCI_THR_RST        16'h0000
`define QCI_CAP_FULL       16'hFFFF

`endif

// ===== hdl/qci_pkg.sv
/*
  types of the quadrature capture block: state structs and the capture unit states.
  assumes: qci_map.svh on the include path.
*/
`default_nettype none
`include "qci_map.svh"

package qci_pkg;

  typedef enum logic [1:0] {
    QCI_CAP_OFF,
    QCI_CAP_LOW,
    QCI_CAP_HIGH
  } qci_cap_type;

  typedef struct packed {
    logic prev_a;
    logic prev_b;
    logic prev_idx;
    logic cnt;
    logic dir;
    logic idx;
  } qci_dec_type;

  typedef struct packed {
    logic [`QCI_CTRL_W-1:0] ctrl;
    logic [31:0]            init_pos;
    logic [31:0]            max_pos;
    logic [31:0]            cmp_shadow;
    logic [31:0]            cmp_active;
    logic [31:0]            unit_prd;
    logic [31:0]            unit_tmr;
    logic [31:0]            pos_latch;
    logic [31:0]            pos;
    logic [15:0]            cap_prd;
    logic [15:0]            cap_tmr;
    logic [6:0]             cap_psc;
    logic [6:0]             up_cnt;
    logic [15:0]            low_thr;
    logic [`QCI_EV_W-1:0]   irq_en;
    logic [`QCI_EV_W-1:0]   irq_sticky;
    logic [`QCI_EV_W-1:0]   flags;
    logic                   last_dir;
    logic                   up_dir;
    logic                   dir_moved;
    logic                   cap_ovf;
    logic                   first_seen;
    qci_cap_type            cap_state;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic                   irq;
  } qci_state_type;

endpackage

`default_nettype wire

// ===== hdl/qci_top.sv
/*
  quadrature capture block: position counter, compare with shadow, unit timer,
  low-speed edge capture, interrupt flags, APB register slave.
  assumes: encoder pins synchronous to CLK_IN; APB master per APB3 with one wait state answered.
*/
// Implementation choices: register access over APB and the address map.
`default_nettype none
`include "qci_map.svh"

// Behaviour
// - reversal between two unit position events sets the direction-change error flag only at low speed, after a low-speed period, with capture enabled
// - capture timer passing 65535 counts between unit events sets capture overflow flag only after a low-speed period
// - above the low speed threshold the capture period measurements stop
// - direction change reaches the interrupt only when its enable is set
// - underflow and overflow reach the interrupt only with their own enables
// - compare match reaches the interrupt only when its enable is set
// - unit timeout reaches the interrupt only when its enable is set
// - interrupt source flags clear themselves one clock after being set
// - position counter is clocked by quadrature decoding only
// - no counter reset on unit timeout; only index and maximum modes exist
// - index resets the counter at once in every-index and first-index modes
// - compare value always goes through a shadow register
// - overflow reloads zero, underflow reloads the maximum position
// - each unit position event clears capture timer; below the low speed threshold, after a low-speed period, it latches it and flags new value
module qci_top (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  // encoder pins
  input  wire logic        PHASE_A_IN,
  input  wire logic        PHASE_B_IN,
  input  wire logic        INDEX_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic [31:0]      PRDATA_OUT,
  // interrupt
  output logic             IRQ_OUT
);

  qci_pkg::qci_state_type s;
  qci_pkg::qci_state_type next_s;

  logic                 dec_cnt;
  logic                 dec_dir;
  logic                 dec_idx;
  logic                 wr_en;
  logic                 up_evt;
  logic                 cap_tick;
  logic                 idx_act;
  logic [`QCI_EV_W-1:0] ev;
  logic [`QCI_EV_W-1:0] clr;

  qci_decoder u_dec (
    .clk_in         (CLK_IN),
    .rst_n_in       (RST_N_IN),
    .phase_a_in     (PHASE_A_IN),
    .phase_b_in     (PHASE_B_IN),
    .index_input_in (INDEX_IN),
    .count_out      (dec_cnt),
    .dir_up_out     (dec_dir),
    .index_out      (dec_idx)
  );

  // all-ones mask of 2^n - 1 for the prescalers
  function automatic logic [6:0] pow2m1(input logic [2:0] n);
    pow2m1 = 7'(({7'h00, 1'b1} << n) - 8'h01);
  endfunction

  // register map decode: mapped flag
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `QCI_CMPACT_OFF) && (a[1:0] == 2'h0);
  endfunction

  always_comb
  begin
    next_s = s;
    ev = '0;
    clr = '0;
    wr_en = PSEL_IN & PENABLE_IN & s.pready & PWRITE_IN & mapped(PADDR_IN);
    up_evt = 1'b0;
    cap_tick = 1'b0;
    idx_act = 1'b0;

    // apb: answer one cycle into the access phase
    next_s.pready = PSEL_IN & PENABLE_IN & ~s.pready;
    next_s.pslverr = PSEL_IN & PENABLE_IN & ~s.pready & ~mapped(PADDR_IN);
    if (PSEL_IN & PENABLE_IN & ~s.pready & ~PWRITE_IN)
    begin
      unique case (PADDR_IN)
        `QCI_CTRL_OFF:   next_s.prdata = {21'h000000, s.ctrl};
        `QCI_POS_OFF:    next_s.prdata = s.pos;
        `QCI_INIT_OFF:   next_s.prdata = s.init_pos;
        `QCI_MAX_OFF:    next_s.prdata = s.max_pos;
        `QCI_CMP_OFF:    next_s.prdata = s.cmp_shadow;
        `QCI_UPRD_OFF:   next_s.prdata = s.unit_prd;
        `QCI_POSLAT_OFF: next_s.prdata = s.pos_latch;
        `QCI_CAPPRD_OFF: next_s.prdata = {16'h0000, s.cap_prd};
        `QCI_THR_OFF:    next_s.prdata = {16'h0000, s.low_thr};
        `QCI_STATUS_OFF: next_s.prdata = {29'h00000000, s.cap_state == qci_pkg::QCI_CAP_LOW,
                                          s.first_seen, s.last_dir};
        `QCI_IRQEN_OFF:  next_s.prdata = {24'h000000, s.irq_en};
        `QCI_IRQST_OFF:  next_s.prdata = {24'h000000, s.irq_sticky};
        `QCI_CMPACT_OFF: next_s.prdata = s.cmp_active;
        default:         next_s.prdata = 32'h00000000;
      endcase
    end

    if (wr_en)
    begin
      unique case (PADDR_IN)
        `QCI_CTRL_OFF:   next_s.ctrl = PWDATA_IN[`QCI_CTRL_W-1:0];
        `QCI_INIT_OFF:   next_s.init_pos = PWDATA_IN;
        `QCI_MAX_OFF:    next_s.max_pos = PWDATA_IN;
        `QCI_CMP_OFF:    next_s.cmp_shadow = PWDATA_IN;
        `QCI_UPRD_OFF:   next_s.unit_prd = PWDATA_IN;
        `QCI_THR_OFF:    next_s.low_thr = PWDATA_IN[15:0];
        `QCI_IRQEN_OFF:  next_s.irq_en = PWDATA_IN[`QCI_EV_W-1:0];
        `QCI_IRQCLR_OFF: clr = PWDATA_IN[`QCI_EV_W-1:0];
        default:         clr = '0;
      endcase
    end

    // position counter, decoded edges only; no unit-timeout reset mode exists
    if (!s.ctrl[`QCI_CTRL_EN])
    begin
      next_s.pos = s.init_pos;
      next_s.first_seen = 1'b0;
      next_s.up_cnt = '0;
    end
    else
    begin
      idx_act = dec_idx && ((s.ctrl[`QCI_CTRL_MODE +: 2] == `QCI_MODE_EVERY_IDX) ||
                ((s.ctrl[`QCI_CTRL_MODE +: 2] == `QCI_MODE_FIRST_IDX) && !s.first_seen));
      if (idx_act)
      begin
        next_s.pos = dec_dir ? 32'h00000000 : s.max_pos;
        next_s.first_seen = 1'b1;
      end
      else if (dec_cnt)
      begin
        if (dec_dir)
        begin
          if (s.pos >= s.max_pos)
          begin
            next_s.pos = 32'h00000000;
            ev[`QCI_EV_OVER] = 1'b1;
          end
          else
          begin
            next_s.pos = s.pos + 32'h00000001;
          end
        end
        else if (s.pos == 32'h00000000)
        begin
          next_s.pos = s.max_pos;
          ev[`QCI_EV_UNDER] = 1'b1;
        end
        else
        begin
          next_s.pos = s.pos - 32'h00000001;
        end
      end
      if (dec_cnt)
      begin
        next_s.last_dir = dec_dir;
        ev[`QCI_EV_DIRCHG] = dec_dir != s.last_dir;
        next_s.dir_moved = s.dir_moved | (dec_dir != s.up_dir);
        up_evt = s.up_cnt == pow2m1(s.ctrl[`QCI_CTRL_UPPS +: 3]);
        next_s.up_cnt = up_evt ? 7'h00 : s.up_cnt + 7'h01;
      end
    end

    // compare: shadow moves to active on match or on counter zero
    if (next_s.pos != s.pos)
    begin
      ev[`QCI_EV_CMP] = next_s.pos == s.cmp_active;
      if (ev[`QCI_EV_CMP] || next_s.pos == 32'h00000000)
      begin
        next_s.cmp_active = s.cmp_shadow;
      end
    end

    // unit timer latches the position each period
    if (s.ctrl[`QCI_CTRL_UTE])
    begin
      if (s.unit_tmr >= s.unit_prd)
      begin
        next_s.unit_tmr = 32'h00000000;
        next_s.pos_latch = s.pos;
        ev[`QCI_EV_UTO] = 1'b1;
      end
      else
      begin
        next_s.unit_tmr = s.unit_tmr + 32'h00000001;
      end
    end
    else
    begin
      next_s.unit_tmr = 32'h00000000;
    end

    // edge capture on the prescaled capture clock
    if (!s.ctrl[`QCI_CTRL_CAPEN] || !s.ctrl[`QCI_CTRL_EN])
    begin
      next_s.cap_state = qci_pkg::QCI_CAP_OFF;
      next_s.cap_tmr = 16'h0000;
      next_s.cap_psc = 7'h00;
      next_s.cap_ovf = 1'b0;
      next_s.dir_moved = 1'b0;
      next_s.up_dir = s.last_dir;
    end
    else
    begin
      cap_tick = s.cap_psc == pow2m1(s.ctrl[`QCI_CTRL_CAPPS +: 3]);
      next_s.cap_psc = cap_tick ? 7'h00 : s.cap_psc + 7'h01;
      if (cap_tick)
      begin
        if (s.cap_tmr == `QCI_CAP_FULL)
        begin
          next_s.cap_ovf = 1'b1;
          ev[`QCI_EV_CAPTURE_OVERFLOW_ERROR_FLAG] = !s.cap_ovf && s.cap_state == qci_pkg::QCI_CAP_LOW;
        end
        else
        begin
          next_s.cap_tmr = s.cap_tmr + 16'h0001;
        end
      end
      unique case (s.cap_state)
        qci_pkg::QCI_CAP_OFF:
        begin
          next_s.cap_state = qci_pkg::QCI_CAP_LOW;
        end
        qci_pkg::QCI_CAP_LOW, qci_pkg::QCI_CAP_HIGH:
        begin
          if (up_evt)
          begin
            next_s.cap_tmr = 16'h0000;
            next_s.cap_ovf = 1'b0;
            next_s.dir_moved = 1'b0;
            next_s.up_dir = dec_dir;
            if (s.cap_tmr < s.low_thr)
            begin
              next_s.cap_state = qci_pkg::QCI_CAP_HIGH;
            end
            else
            begin
              next_s.cap_state = qci_pkg::QCI_CAP_LOW;
              if (s.cap_state == qci_pkg::QCI_CAP_LOW)
              begin
                next_s.cap_prd = s.cap_tmr;
                ev[`QCI_EV_CAPNEW] = 1'b1;
                ev[`QCI_EV_DIRECTION_CHANGE_ERROR_FLAG] = s.dir_moved || dec_dir != s.up_dir;
              end
            end
          end
        end
      endcase
    end

    // flags last one cycle; sticky copy set wins over clear
    next_s.flags = ev;
    next_s.irq_sticky = (s.irq_sticky & ~clr) | ev;
    next_s.irq = |((next_s.irq_sticky | next_s.flags) & next_s.irq_en);
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      s <= '0;
      s.ctrl <= `QCI_CTRL_RST;
      s.max_pos <= `QCI_MAX_RST;
      s.unit_prd <= `QCI_UPRD_RST;
      s.low_thr <= `QCI_THR_RST;
      s.last_dir <= 1'b1;
      s.up_dir <= 1'b1;
      s.cap_state <= qci_pkg::QCI_CAP_OFF;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign PREADY_OUT = s.pready;
  assign PSLVERR_OUT = s.pslverr;
  assign PRDATA_OUT = s.prdata;
  assign IRQ_OUT = s.irq;

  ovf_wrap_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s.ctrl[`QCI_CTRL_EN] && dec_cnt && dec_dir && !dec_idx && s.pos == s.max_pos
    |=> s.pos == 32'h00000000 && s.flags[`QCI_EV_OVER])
    else $error("overflow did not wrap to zero");

  udf_wrap_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s.ctrl[`QCI_CTRL_EN] && dec_cnt && !dec_dir && !dec_idx && s.pos == 32'h00000000
    |=> s.pos == $past(s.max_pos) && s.flags[`QCI_EV_UNDER])
    else $error("underflow did not reload maximum");

  index_reset_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s.ctrl[`QCI_CTRL_EN] && dec_idx && dec_dir && s.ctrl[`QCI_CTRL_MODE +: 2] == `QCI_MODE_EVERY_IDX
    |=> s.pos == 32'h00000000)
    else $error("index did not reset position");

  shadow_load_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s.cmp_active != $past(s.cmp_active) |-> s.pos == 32'h00000000 || s.flags[`QCI_EV_CMP])
    else $error("active compare changed without load event");

  timeout_pulse_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s.flags[`QCI_EV_UTO] && s.unit_prd != 32'h00000000 && $stable(s.unit_prd)
    |=> !s.flags[`QCI_EV_UTO])
    else $error("timeout flag stayed set");

  irq_gate_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ((s.irq_sticky | s.flags) & s.irq_en) == '0 |-> !IRQ_OUT)
    else $error("interrupt without an enabled source");

  cap_latch_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s.cap_state == qci_pkg::QCI_CAP_LOW && up_evt && s.cap_tmr >= s.low_thr
    && s.ctrl[`QCI_CTRL_CAPEN] && s.ctrl[`QCI_CTRL_EN]
    |=> s.cap_prd == $past(s.cap_tmr) && s.cap_tmr <= 16'h0001 && s.flags[`QCI_EV_CAPNEW])
    else $error("capture period not latched");

  cap_ovf_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s.cap_state == qci_pkg::QCI_CAP_LOW && cap_tick && !up_evt && !s.cap_ovf && s.cap_tmr == `QCI_CAP_FULL
    |=> s.flags[`QCI_EV_CAPTURE_OVERFLOW_ERROR_FLAG] ##1 !s.flags[`QCI_EV_CAPTURE_OVERFLOW_ERROR_FLAG])
    else $error("capture overflow flag missing");

  dir_err_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s.cap_state == qci_pkg::QCI_CAP_LOW && up_evt && s.cap_tmr >= s.low_thr && s.dir_moved
    && s.ctrl[`QCI_CTRL_CAPEN] |=> s.flags[`QCI_EV_DIRECTION_CHANGE_ERROR_FLAG])
    else $error("direction change error not flagged");

  high_speed_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s.cap_state == qci_pkg::QCI_CAP_HIGH |=> $stable(s.cap_prd) && !s.flags[`QCI_EV_CAPNEW])
    else $error("capture measured above speed threshold");

endmodule

`default_nettype wire

// ===== test/qci_enc_model.sv
/*
  quadrature encoder model: gray-coded phase pair and an index pulse, stepped on request.
  assumes: the bench calls its tasks; it shares the block's clock and changes pins after a rising edge.
*/
`default_nettype none

module qci_enc_model (
  // clock
  input  wire logic clk_in,
  // encoder pins
  output logic      phase_a_out,
  output logic      phase_b_out,
  output logic      index_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] st = 2'h0;

  // one phase changes per step, a leads b when counting up
  assign phase_a_out = ^st;
  assign phase_b_out = st[1];

  initial index_out = 1'b0;

  task automatic step(input logic up);
    @(posedge clk_in);
    st <= up ? st + 2'h1 : st - 2'h1;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic pulse_index();
    @(posedge clk_in);
    index_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    index_out <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
endmodule

`default_nettype wire

// ===== test/test_qci_top.sv
/*
  testbench of the quadrature capture block: apb tasks, one task per scenario.
  assumes: qci_map.svh on the include path; encoder model in its own file.
*/
`default_nettype none
`include "qci_map.svh"

module test_qci_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] ALL = 32'hFFFFFFFF;

  logic        clk_in  = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        irq;
  logic        enc_a;
  logic        enc_b;
  logic        enc_idx;
  logic [31:0] rdat;
  logic        rerr;
  int          fails   = 0;
  int          checks  = 0;

  always #5 clk_in = ~clk_in;

  qci_enc_model i_enc (.clk_in(clk_in), .phase_a_out(enc_a), .phase_b_out(enc_b), .index_out(enc_idx));

  qci_top i_dut (
    .CLK_IN(clk_in), .RST_N_IN(rst_n), .PHASE_A_IN(enc_a), .PHASE_B_IN(enc_b), .INDEX_IN(enc_idx),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata), .IRQ_OUT(irq)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // setup, access held until pready sampled high, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    // no local limit: only the watchdog ends a wait for pready
    while (pready !== 1'b1)
    begin
      @(posedge clk_in);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), exp, rdat & m);
  endtask

  task automatic steps(input int k, input logic up, input int gap);
    repeat (k)
    begin
      i_enc.step(up);
      repeat (gap) @(posedge clk_in);
    end
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk_in);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic t_reset();
    rd(`QCI_CTRL_OFF, ALL, 32'h0);
    rd(`QCI_MAX_OFF, ALL, `QCI_MAX_RST);
    rd(`QCI_UPRD_OFF, ALL, `QCI_UPRD_RST);
    rd(`QCI_IRQEN_OFF, ALL, 32'h0);
    rd(`QCI_IRQST_OFF, ALL, 32'h0);
    apb(1'b0, 8'h38, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    wr(`QCI_POS_OFF, 32'h5);
    rd(`QCI_POS_OFF, ALL, 32'h0);
  endtask

  task automatic t_wrap();
    wr(`QCI_INIT_OFF, 32'h1);
    wr(`QCI_MAX_OFF, 32'h3);
    wr(`QCI_CTRL_OFF, 32'h3);
    rd(`QCI_POS_OFF, ALL, 32'h1);
    steps(3, 1'b1, 0);
    rd(`QCI_POS_OFF, ALL, 32'h0);
    rd(`QCI_IRQST_OFF, 32'h4, 32'h4);
    irq_is(1'b0);
    wr(`QCI_IRQEN_OFF, 32'h4);
    irq_is(1'b1);
    wr(`QCI_IRQCLR_OFF, 32'hFF);
    irq_is(1'b0);
    steps(1, 1'b0, 0);
    rd(`QCI_POS_OFF, ALL, 32'h3);
    rd(`QCI_IRQST_OFF, 32'h3, 32'h3);
    irq_is(1'b0);
    wr(`QCI_IRQEN_OFF, 32'h2);
    irq_is(1'b1);
    wr(`QCI_IRQEN_OFF, 32'h1);
    irq_is(1'b1);
    wr(`QCI_IRQEN_OFF, 32'h0);
    wr(`QCI_CTRL_OFF, 32'h0);
  endtask

  task automatic t_index();
    wr(`QCI_INIT_OFF, 32'h0);
    wr(`QCI_MAX_OFF, 32'h63);
    wr(`QCI_UPRD_OFF, 32'h9);
    wr(`QCI_CTRL_OFF, 32'h9);
    wr(`QCI_IRQCLR_OFF, 32'hFF);
    steps(5, 1'b1, 0);
    rd(`QCI_POS_OFF, ALL, 32'h5);
    i_enc.pulse_index();
    rd(`QCI_POS_OFF, ALL, 32'h0);
    steps(2, 1'b1, 40);
    rd(`QCI_POS_OFF, ALL, 32'h2);
    rd(`QCI_IRQST_OFF, 32'h10, 32'h10);
    irq_is(1'b0);
    wr(`QCI_IRQEN_OFF, 32'h10);
    irq_is(1'b1);
    wr(`QCI_IRQEN_OFF, 32'h0);
    i_enc.pulse_index();
    rd(`QCI_POS_OFF, ALL, 32'h0);
    wr(`QCI_CTRL_OFF, 32'h0);
    wr(`QCI_CTRL_OFF, 32'h5);
    steps(3, 1'b1, 0);
    i_enc.pulse_index();
    steps(2, 1'b1, 0);
    i_enc.pulse_index();
    rd(`QCI_POS_OFF, ALL, 32'h2);
    wr(`QCI_CTRL_OFF, 32'h0);
  endtask

  task automatic t_cmp();
    wr(`QCI_MAX_OFF, 32'h7);
    wr(`QCI_CMP_OFF, 32'h5);
    rd(`QCI_CMPACT_OFF, ALL, 32'h0);
    wr(`QCI_CTRL_OFF, 32'h3);
    steps(8, 1'b1, 0);
    rd(`QCI_CMPACT_OFF, ALL, 32'h5);
    wr(`QCI_CMP_OFF, 32'h6);
    rd(`QCI_CMPACT_OFF, ALL, 32'h5);
    wr(`QCI_IRQCLR_OFF, 32'hFF);
    wr(`QCI_IRQEN_OFF, 32'h8);
    irq_is(1'b0);
    steps(5, 1'b1, 0);
    rd(`QCI_IRQST_OFF, 32'h8, 32'h8);
    irq_is(1'b1);
    wr(`QCI_IRQEN_OFF, 32'h0);
    wr(`QCI_CTRL_OFF, 32'h0);
  endtask

  task automatic t_cap();
    wr(`QCI_MAX_OFF, ALL);
    wr(`QCI_THR_OFF, 32'h0);
    wr(`QCI_CTRL_OFF, 32'h13);
    wr(`QCI_IRQCLR_OFF, 32'hFF);
    steps(3, 1'b1, 16);
    rd(`QCI_IRQST_OFF, 32'hE0, 32'h20);
    apb(1'b0, `QCI_CAPPRD_OFF, 32'h0);
    chk("capture period", 32'h1, {31'h0, rdat >= 32'h13 && rdat <= 32'h14});
    wr(`QCI_IRQCLR_OFF, 32'hFF);
    steps(1, 1'b0, 16);
    rd(`QCI_IRQST_OFF, 32'hC0, 32'h40);
    wr(`QCI_IRQCLR_OFF, 32'hFF);
    repeat (66000) @(posedge clk_in);
    steps(1, 1'b0, 16);
    rd(`QCI_IRQST_OFF, 32'hC0, 32'h80);
    wr(`QCI_THR_OFF, 32'h3E8);
    steps(2, 1'b0, 16);
    wr(`QCI_IRQCLR_OFF, 32'hFF);
    steps(3, 1'b0, 16);
    rd(`QCI_IRQST_OFF, 32'h20, 32'h0);
    rd(`QCI_STATUS_OFF, 32'h4, 32'h0);
    // capture clock halved, unit event every second count: 40 cycles give 19 or 20 ticks
    wr(`QCI_THR_OFF, 32'h0);
    wr(`QCI_CTRL_OFF, 32'h0);
    wr(`QCI_CTRL_OFF, 32'h133);
    steps(4, 1'b1, 16);
    apb(1'b0, `QCI_CAPPRD_OFF, 32'h0);
    chk("prescaled period", 32'h1, {31'h0, rdat >= 32'h13 && rdat <= 32'h14});
    wr(`QCI_CTRL_OFF, 32'h0);
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_n <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_wrap();
    t_index();
    t_cmp();
    t_cap();
    conclude();
  end

  initial
  begin
    repeat (90000) @(posedge clk_in);
    fails++;
    conclude();
  end
endmodule

`default_nettype wire
